// ==== tb/ebr_periph_model.sv ====
// Behavioural model of the internal peripherals facing the route selector.
module ebr_periph_model
    import ebr_pkg::*;
(
    // Clock and reset
    input  wire logic                                        clk,
    input  wire logic                                        sys_rst,
    // Control from the bench
    input  wire logic                                        gated,
    input  wire logic                                        restart,
    input  wire logic [31:0]                                 seed,
    // Drives towards the pins
    output ebr_pkg::ebr_drv_type [ebr_pkg::EBR_FN_COUNT-1:0] periph_drv
);
    timeunit 1ns;
    timeprecision 100ps;

    ebr_drv_type [EBR_FN_COUNT-1:0] drv_reg;
    ebr_drv_type [EBR_FN_COUNT-1:0] drv_next;
    logic        [31:0]             mix;

    // ==================================================================
    // Drive pattern
    // A gated peripheral drives nothing; a restart loads a fresh pattern.
    // gate and restart
    always_comb begin
        drv_next = drv_reg;
        mix      = seed;
        if (gated) begin
            drv_next = '0;
        end else if (restart) begin
            for (int f = 1; f < EBR_FN_COUNT; f++) begin
                mix         = mix ^ (mix << 13);
                mix         = mix ^ (mix >> 17);
                mix         = mix ^ (mix << 5);
                drv_next[f] = mix[15:0];
            end
        end
    end

    // Registers the pattern; reset leaves every peripheral quiet.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            drv_reg <= '0;
        end else begin
            drv_reg <= drv_next;
        end
    end

    assign periph_drv = drv_reg;

endmodule : ebr_periph_model

// ==== tb/test_ebr_route_select.sv ====
// Self-checking bench for the external bus pin route selector.
module test_ebr_route_select
    import ebr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic                           clk;
    logic                           sys_rst;
    logic [15:0]                    reg_addr;
    logic [15:0]                    reg_wdata;
    logic                           reg_wr;
    logic                           reg_rd;
    logic [15:0]                    reg_rdata;
    ebr_drv_type [EBR_FN_COUNT-1:0] periph_drv;
    logic [EBR_FN_COUNT-1:0][7:0]   periph_in;
    logic [20:0]                    pp_pin_in;
    logic [20:0]                    pp_pin_out;
    logic [20:0]                    pp_pin_oe;
    logic [5:0]                     sp0_pin_in;
    logic [5:0]                     sp0_pin_out;
    logic [5:0]                     sp0_pin_oe;
    logic [5:0]                     sp1_pin_in;
    logic [5:0]                     sp1_pin_out;
    logic [5:0]                     sp1_pin_oe;
    logic                           gated;
    logic                           restart;
    logic [31:0]                    seed;
    logic [31:0]                    rnd_state;
    logic [15:0]                    rd_word;
    ebr_fields_type                 fields;
    int                             n_mismatch;
    int                             n_tests;

    ebr_route_select i_dut (.clk(clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_drv(periph_drv),
        .periph_in(periph_in), .pp_pin_in(pp_pin_in),
        .pp_pin_out(pp_pin_out), .pp_pin_oe(pp_pin_oe),
        .sp0_pin_in(sp0_pin_in), .sp0_pin_out(sp0_pin_out),
        .sp0_pin_oe(sp0_pin_oe), .sp1_pin_in(sp1_pin_in),
        .sp1_pin_out(sp1_pin_out), .sp1_pin_oe(sp1_pin_oe));

    ebr_periph_model i_periph (.clk(clk), .sys_rst(sys_rst), .gated(gated),
        .restart(restart), .seed(seed), .periph_drv(periph_drv));

    // ==================================================================
    // Helpers
    // Xorshift source; every call advances the fixed-seed sequence.
    function automatic logic [31:0] next_rand();
        rnd_state = rnd_state ^ (rnd_state << 13);
        rnd_state = rnd_state ^ (rnd_state >> 17);
        rnd_state = rnd_state ^ (rnd_state << 5);
        return rnd_state;
    endfunction : next_rand

    function automatic ebr_route_type mk(ebr_func_type f, int i);
        ebr_route_type r;
        r.func = f;
        r.idx  = 3'(i);
        return r;
    endfunction : mk

    // Owner of a pin (0-20 parallel, 21-26 port 0, 27-32 port 1).
    function automatic ebr_route_type route_of(ebr_fields_type fl, int pin);
        ebr_route_type   r;
        ebr_sp_mode_type m;
        logic            one;
        int              p;
        r   = mk(FN_NONE, 0);
        one = (pin >= EBR_SP1_BASE);
        p   = one ? pin - EBR_SP1_BASE : pin - EBR_SP0_BASE;
        m   = one ? fl.sp1 : fl.sp0;
        if (pin >= EBR_SP0_BASE) begin
            case (m)
                SP_CARD: r = mk(one ? FN_MMC1 : FN_MMC0, p);
                SP_I2S_GPIO: r = mk(p < 4 ? (one ? FN_I2S1 : FN_I2S0)
                                    : (one ? FN_GPIO_SP1 : FN_GPIO_SP0), p);
                SP_GPIO: r = mk(one ? FN_GPIO_SP1 : FN_GPIO_SP0, p);
                default: r = mk(FN_NONE, 0);
            endcase
            return r;
        end
        case (fl.pp)
            PP_SGUI, PP_SPI_I2S_GPIO: begin
                if (pin < 7) r = mk(FN_SPI, pin);
                else if (pin < 13) r = mk(FN_GPIO_PP, pin - 7);
                else if (pin < 17) r = mk(fl.pp == PP_SGUI ? FN_UART
                                                          : FN_I2S3, pin - 13);
                else r = mk(FN_I2S2, pin - 17);
            end
            PP_GPIO: if (pin >= 7 && pin < 15) r = mk(FN_GPIO_PP, pin - 7);
            PP_SPI_I2S3: begin
                if (pin < 4) r = mk(FN_SPI, pin);
                else if (pin >= 13 && pin < 17) r = mk(FN_I2S3, pin - 13);
            end
            PP_I2S2_UART: begin
                if (pin >= 13 && pin < 17) r = mk(FN_UART, pin - 13);
                else if (pin >= 17) r = mk(FN_I2S2, pin - 17);
            end
            PP_SPI_UART: begin
                if (pin < 4) r = mk(FN_SPI, pin);
                else if (pin >= 13 && pin < 17) r = mk(FN_UART, pin - 13);
            end
            default: r = mk(FN_NONE, 0);
        endcase
        return r;
    endfunction : route_of

    // Counts one comparison and reports a mismatch at once.
    task automatic cmp(logic [63:0] got, logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    // Compares every pin and every peripheral input with the given routing.
    task automatic check_all(ebr_fields_type fl);
        logic [32:0]                  pin_in;
        logic [32:0]                  exp_out;
        logic [32:0]                  exp_oe;
        logic [EBR_FN_COUNT-1:0][7:0] exp_in;
        ebr_route_type                r;
        pin_in  = {sp1_pin_in, sp0_pin_in, pp_pin_in};
        exp_out = '0;
        exp_oe  = '0;
        exp_in  = '0;
        for (int i = 0; i < EBR_ALL_PINS; i++) begin
            r = route_of(fl, i);
            if (r.func != FN_NONE) begin
                exp_out[i]            = periph_drv[r.func].out[r.idx];
                exp_oe[i]             = periph_drv[r.func].oe[r.idx];
                exp_in[r.func][r.idx] = pin_in[i];
            end
        end
        cmp(64'({sp1_pin_out, sp0_pin_out, pp_pin_out}), 64'(exp_out));
        cmp(64'({sp1_pin_oe, sp0_pin_oe, pp_pin_oe}), 64'(exp_oe));
        for (int f = 0; f < EBR_FN_COUNT; f++) begin
            cmp(64'(periph_in[f]), 64'(exp_in[f]));
        end
    endtask : check_all

    // One write cycle; returns at the edge that takes it.
    task automatic bus_write(logic [15:0] a, logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : bus_write

    // One read cycle; data are taken in the cycle after the strobe.
    task automatic bus_read(logic [15:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : bus_read

    // Loads a fresh random pattern into peripherals and pins.
    task automatic reload();
        @(posedge clk);
        restart    <= 1'b1;
        seed       <= next_rand();
        pp_pin_in  <= 21'(next_rand());
        sp0_pin_in <= 6'(next_rand());
        sp1_pin_in <= 6'(next_rand());
        @(posedge clk);
        restart <= 1'b0;
        @(posedge clk);
        #1;
    endtask : reload

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // ==================================================================
    // Clock and watchdog
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Cuts a hang short far beyond the expected run of some 220 cycles.
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end

    // ==================================================================
    // Main sequence
    initial begin
        rnd_state  = 32'h0000005e;
        sys_rst    = 1'b1;
        reg_addr   = 16'h0000;
        reg_wdata  = 16'h0000;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        gated      = 1'b0;
        restart    = 1'b0;
        seed       = 32'h00000001;
        pp_pin_in  = '0;
        sp0_pin_in = '0;
        sp1_pin_in = '0;
        n_mismatch = 0;
        n_tests    = 0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        // Reset routing: parallel off, serial ports on the card controllers.
        fields = '0;
        reload();
        check_all(fields);
        bus_read(EBR_SEL_ADDR, rd_word);
        cmp(64'(rd_word), 64'h0);
        // Reserved and unused bits set; only the field bits may stick.
        bus_write(EBR_SEL_ADDR, 16'he9ff);
        #1;
        check_all(fields);
        fields = ebr_fields_type'(7'h69);
        @(posedge clk);
        #1;
        check_all(fields);
        bus_read(EBR_SEL_ADDR, rd_word);
        cmp(64'(rd_word), 64'h6900);
        // Read data stand one cycle only, then fall back to zero.
        @(posedge clk);
        #1;
        cmp(64'(reg_rdata), 64'h0);
        // A neighbouring address neither changes nor shows the fields.
        bus_write(EBR_SEL_ADDR + 16'h0001, 16'h2000);
        bus_read(EBR_SEL_ADDR, rd_word);
        cmp(64'(rd_word), 64'h6900);
        bus_read(EBR_SEL_ADDR + 16'h0001, rd_word);
        cmp(64'(rd_word), 64'h0);
        // Every parallel mode against every defined serial mode.
        for (int m = 0; m < 8; m++) begin
            for (int k = 0; k < 3; k++) begin
                fields.pp  = ebr_pp_mode_type'(3'(m));
                fields.sp0 = ebr_sp_mode_type'(2'(k));
                fields.sp1 = ebr_sp_mode_type'(2'((k + m) % 3));
                @(posedge clk);
                gated <= 1'b1;
                bus_write(EBR_SEL_ADDR, {1'b0, fields, 8'(next_rand())});
                gated <= 1'b0;
                reload();
                check_all(fields);
                bus_read(EBR_SEL_ADDR, rd_word);
                cmp(64'(rd_word), 64'({1'b0, fields, 8'h00}));
            end
        end
        tally_and_finish();
    end

endmodule : test_ebr_route_select

// ==== verilog/ebr_pin_cell.sv ====
// One pin driver: picks the owning peripheral's output and enable.
module ebr_pin_cell
    import ebr_pkg::*;
(
    // Routing of this pin
    input  ebr_pkg::ebr_route_type                       route,
    // Drives from every peripheral
    input  ebr_pkg::ebr_drv_type [ebr_pkg::EBR_FN_COUNT-1:0] drv,
    // Next pin values
    output logic                                         out_next,
    output logic                                         oe_next
);

    // A pin with no owner stays undriven and low.
    always_comb begin
        out_next = 1'b0;
        oe_next  = 1'b0;
        if (route.func != FN_NONE) begin
            out_next = drv[route.func].out[route.idx];
            oe_next  = drv[route.func].oe[route.idx];
        end
    end

endmodule : ebr_pin_cell

// ==== verilog/ebr_pkg.sv ====
// Constants and types shared by the external bus pin route selector.
package ebr_pkg;

    // ==================================================================
    // Register map and field layout
    localparam logic [15:0] EBR_SEL_ADDR = 16'h1c00;
    localparam int          EBR_PP_LSB   = 12;
    localparam int          EBR_PP_MSB   = 14;
    localparam int          EBR_SP1_LSB  = 10;
    localparam int          EBR_SP1_MSB  = 11;
    localparam int          EBR_SP0_LSB  = 8;
    localparam int          EBR_SP0_MSB  = 9;
    localparam logic [2:0]  EBR_PP_RST   = 3'h0;
    localparam logic [1:0]  EBR_SP_RST   = 2'h0;

    // ==================================================================
    // Pin counts and home positions of each function on the ports
    localparam int EBR_PP_PINS  = 21;
    localparam int EBR_SP_PINS  = 6;
    localparam int EBR_ALL_PINS = 33;
    localparam int EBR_SP0_BASE = 21;
    localparam int EBR_SP1_BASE = 27;
    localparam int EBR_SPI_BASE = 0;
    localparam int EBR_GPIO_BASE = 7;
    localparam int EBR_UART_BASE = 13;
    localparam int EBR_I2S3_BASE = 13;
    localparam int EBR_I2S2_BASE = 17;
    localparam int EBR_SPI_FULL = 7;
    localparam int EBR_SPI_HALF = 4;
    localparam int EBR_GPIO_SIX = 6;
    localparam int EBR_GPIO_EIGHT = 8;
    localparam int EBR_FOUR     = 4;
    localparam int EBR_GPIO_LOW = 4;

    // ==================================================================
    // Routing modes
    typedef enum logic [2:0] {
        PP_OFF       = 3'b000,
        PP_SGUI      = 3'b001,
        PP_GPIO      = 3'b010,
        PP_SPI_I2S3  = 3'b011,
        PP_I2S2_UART = 3'b100,
        PP_SPI_UART  = 3'b101,
        PP_SPI_I2S_GPIO = 3'b110,
        PP_UNDEF     = 3'b111
    } ebr_pp_mode_type;

    typedef enum logic [1:0] {
        SP_CARD   = 2'b00,
        SP_I2S_GPIO = 2'b01,
        SP_GPIO   = 2'b10,
        SP_RSVD   = 2'b11
    } ebr_sp_mode_type;

    // Peripheral functions that may own a pin.
    typedef enum logic [3:0] {
        FN_NONE   = 4'h0,
        FN_SPI    = 4'h1,
        FN_UART   = 4'h2,
        FN_I2S0   = 4'h3,
        FN_I2S1   = 4'h4,
        FN_I2S2   = 4'h5,
        FN_I2S3   = 4'h6,
        FN_MMC0   = 4'h7,
        FN_MMC1   = 4'h8,
        FN_GPIO_PP  = 4'h9,
        FN_GPIO_SP0 = 4'ha,
        FN_GPIO_SP1 = 4'hb
    } ebr_func_type;
    localparam int EBR_FN_COUNT = 12;

    // ==================================================================
    // Carriers
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } ebr_drv_type;

    typedef struct packed {
        ebr_func_type func;
        logic [2:0]   idx;
    } ebr_route_type;

    typedef struct packed {
        ebr_pp_mode_type pp;
        ebr_sp_mode_type sp1;
        ebr_sp_mode_type sp0;
    } ebr_fields_type;

endpackage : ebr_pkg

// ==== verilog/ebr_route_select.sv ====
// External bus pin route selector with its selection register.
// Function
// - Bits 15, 7, 6 are read-only; writes never change them or routing.
// - Bits 14:12 choose the parallel port routing over 21 pins.
// - Mode 001 routes 7 SPI, 6 GPIO, 4 UART, 4 second I2S signals.
// - Mode 010 routes eight GPIO signals only.
// - Mode 011 routes 4 SPI and 4 third I2S signals.
// - Mode 100 routes 4 second I2S and 4 UART signals.
// - Mode 101 routes 4 SPI and 4 UART signals.
// - Mode 110 routes 7 SPI, 4+4 I2S, 6 GPIO signals.
// - Bits 11:10 choose serial port 1 routing over six pins.
// - Port 1 mode 01 routes four I2S signals plus GPIO 11 and 10.
// - Port 1 mode 10 routes GPIO 11 down to 6.
// - Bits 9:8 choose serial port 0 routing over six pins.
// - Port 0 mode 00 routes all six card controller signals.
// - Port 0 mode 01 routes four I2S signals plus GPIO 5 and 4.
// - Port 0 mode 10 routes GPIO 5 down to 0.
// - New routing takes effect on the next clock cycle.
// - All routing fields reset to zero.
module ebr_route_select
    import ebr_pkg::*;
(
    // Clock and reset
    input  wire logic                                    clk,
    input  wire logic                                    sys_rst,
    // Register port
    input  wire logic [15:0]                             reg_addr,
    input  wire logic [15:0]                             reg_wdata,
    input  wire logic                                    reg_wr,
    input  wire logic                                    reg_rd,
    output logic      [15:0]                             reg_rdata,
    // Peripheral side
    input  ebr_pkg::ebr_drv_type [ebr_pkg::EBR_FN_COUNT-1:0] periph_drv,
    output logic [ebr_pkg::EBR_FN_COUNT-1:0][7:0]        periph_in,
    // Parallel port pins
    input  wire logic [20:0]                             pp_pin_in,
    output logic      [20:0]                             pp_pin_out,
    output logic      [20:0]                             pp_pin_oe,
    // Serial port 0 pins
    input  wire logic [5:0]                              sp0_pin_in,
    output logic      [5:0]                              sp0_pin_out,
    output logic      [5:0]                              sp0_pin_oe,
    // Serial port 1 pins
    input  wire logic [5:0]                              sp1_pin_in,
    output logic      [5:0]                              sp1_pin_out,
    output logic      [5:0]                              sp1_pin_oe
);
    import ebr_pkg::*;

    // ==================================================================
    // Routing decode functions

    // Claims pin p for function f when it lies in [base, base+cnt).
    function automatic ebr_route_type take(ebr_func_type f, int p,
                                           int base, int cnt,
                                           ebr_route_type r);
        ebr_route_type t;
        t = r;
        if (p >= base && p < base + cnt) begin
            t.func = f;
            t.idx  = 3'(p - base);
        end
        return t;
    endfunction : take

    // Owner of parallel pin p in mode m.
    function automatic ebr_route_type pp_route(ebr_pp_mode_type m, int p);
        ebr_route_type r;
        r = '{FN_NONE, 3'h0};
        case (m)
            PP_SGUI: begin
                r = take(FN_SPI, p, EBR_SPI_BASE, EBR_SPI_FULL, r);
                r = take(FN_GPIO_PP, p, EBR_GPIO_BASE, EBR_GPIO_SIX, r);
                r = take(FN_UART, p, EBR_UART_BASE, EBR_FOUR, r);
                r = take(FN_I2S2, p, EBR_I2S2_BASE, EBR_FOUR, r);
            end
            PP_GPIO: begin
                r = take(FN_GPIO_PP, p, EBR_GPIO_BASE, EBR_GPIO_EIGHT, r);
            end
            PP_SPI_I2S3: begin
                r = take(FN_SPI, p, EBR_SPI_BASE, EBR_SPI_HALF, r);
                r = take(FN_I2S3, p, EBR_I2S3_BASE, EBR_FOUR, r);
            end
            PP_I2S2_UART: begin
                r = take(FN_UART, p, EBR_UART_BASE, EBR_FOUR, r);
                r = take(FN_I2S2, p, EBR_I2S2_BASE, EBR_FOUR, r);
            end
            PP_SPI_UART: begin
                r = take(FN_SPI, p, EBR_SPI_BASE, EBR_SPI_HALF, r);
                r = take(FN_UART, p, EBR_UART_BASE, EBR_FOUR, r);
            end
            PP_SPI_I2S_GPIO: begin
                r = take(FN_SPI, p, EBR_SPI_BASE, EBR_SPI_FULL, r);
                r = take(FN_GPIO_PP, p, EBR_GPIO_BASE, EBR_GPIO_SIX, r);
                r = take(FN_I2S3, p, EBR_I2S3_BASE, EBR_FOUR, r);
                r = take(FN_I2S2, p, EBR_I2S2_BASE, EBR_FOUR, r);
            end
            default: begin
                r = '{FN_NONE, 3'h0};
            end
        endcase
        return r;
    endfunction : pp_route

    // Owner of serial pin p; the GPIO pair sits on the top two pins.
    function automatic ebr_route_type sp_route(ebr_sp_mode_type m, int p,
                                               ebr_func_type card,
                                               ebr_func_type i2s,
                                               ebr_func_type gpio);
        ebr_route_type r;
        r = '{FN_NONE, 3'h0};
        case (m)
            SP_CARD: begin
                r = take(card, p, 0, EBR_SP_PINS, r);
            end
            SP_I2S_GPIO: begin
                r = take(gpio, p, EBR_GPIO_LOW, EBR_SP_PINS - EBR_GPIO_LOW, r);
                r.idx = (r.func == gpio) ? 3'(p) : r.idx;
                r = take(i2s, p, 0, EBR_GPIO_LOW, r);
            end
            SP_GPIO: begin
                r = take(gpio, p, 0, EBR_SP_PINS, r);
            end
            default: begin
                r = '{FN_NONE, 3'h0};
            end
        endcase
        return r;
    endfunction : sp_route

    // ==================================================================
    // Selection register

    ebr_fields_type fields_reg;
    ebr_fields_type fields_next;
    logic [15:0]    rdata_next;
    logic           sel_hit;

    assign sel_hit = (reg_addr == EBR_SEL_ADDR);

    // Write takes only the routing fields; read builds the word.
    always_comb begin
        fields_next = fields_reg;
        rdata_next  = 16'h0000;
        if (reg_wr && sel_hit) begin
            fields_next.pp  = ebr_pp_mode_type'(
                              reg_wdata[EBR_PP_MSB:EBR_PP_LSB]);
            fields_next.sp1 = ebr_sp_mode_type'(
                              reg_wdata[EBR_SP1_MSB:EBR_SP1_LSB]);
            fields_next.sp0 = ebr_sp_mode_type'(
                              reg_wdata[EBR_SP0_MSB:EBR_SP0_LSB]);
        end
        if (reg_rd && sel_hit) begin
            rdata_next[EBR_PP_MSB:EBR_PP_LSB]   = fields_reg.pp;
            rdata_next[EBR_SP1_MSB:EBR_SP1_LSB] = fields_reg.sp1;
            rdata_next[EBR_SP0_MSB:EBR_SP0_LSB] = fields_reg.sp0;
        end
    end

    // Registers the fields and the read data.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fields_reg <= '{PP_OFF, SP_CARD, SP_CARD};
            reg_rdata  <= 16'h0000;
        end else begin
            fields_reg <= fields_next;
            reg_rdata  <= rdata_next;
        end
    end

    // ==================================================================
    // Pin routing

    ebr_route_type [EBR_ALL_PINS-1:0] route;
    logic [EBR_ALL_PINS-1:0]          pin_in;
    logic [EBR_ALL_PINS-1:0]          out_next;
    logic [EBR_ALL_PINS-1:0]          oe_next;
    logic [EBR_FN_COUNT-1:0][7:0]     periph_in_next;

    assign pin_in = {sp1_pin_in, sp0_pin_in, pp_pin_in};

    always_comb begin
        for (int p = 0; p < EBR_ALL_PINS; p++) begin
            if (p < EBR_SP0_BASE) begin
                route[p] = pp_route(fields_reg.pp, p);
            end else if (p < EBR_SP1_BASE) begin
                route[p] = sp_route(fields_reg.sp0, p - EBR_SP0_BASE,
                                    FN_MMC0, FN_I2S0, FN_GPIO_SP0);
            end else begin
                route[p] = sp_route(fields_reg.sp1, p - EBR_SP1_BASE,
                                    FN_MMC1, FN_I2S1, FN_GPIO_SP1);
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < EBR_ALL_PINS; gi++) begin : g_cell
            ebr_pin_cell u_cell (
                .route    (route[gi]),
                .drv      (periph_drv),
                .out_next (out_next[gi]),
                .oe_next  (oe_next[gi])
            );
        end
    endgenerate

    always_comb begin
        periph_in_next = '0;
        for (int p = 0; p < EBR_ALL_PINS; p++) begin
            if (route[p].func != FN_NONE) begin
                periph_in_next[route[p].func][route[p].idx] = pin_in[p];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pp_pin_out  <= 21'h0;
            pp_pin_oe   <= 21'h0;
            sp0_pin_out <= 6'h00;
            sp0_pin_oe  <= 6'h00;
            sp1_pin_out <= 6'h00;
            sp1_pin_oe  <= 6'h00;
            periph_in   <= '0;
        end else begin
            pp_pin_out  <= out_next[20:0];
            pp_pin_oe   <= oe_next[20:0];
            sp0_pin_out <= out_next[26:21];
            sp0_pin_oe  <= oe_next[26:21];
            sp1_pin_out <= out_next[32:27];
            sp1_pin_oe  <= oe_next[32:27];
            periph_in   <= periph_in_next;
        end
    end

    // ==================================================================
    // Assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence sel_write_s;
        reg_wr && sel_hit;
    endsequence

    sequence sel_read_s;
        reg_rd && sel_hit;
    endsequence

    rsv_read_zero_a: assert property (
        sel_read_s |=> reg_rdata[15] == 1'b0 && reg_rdata[7:6] == 2'b00)
        else $error("Reserved bits read non-zero.");

    write_next_a: assert property (
        sel_write_s |=> fields_reg ==
                        $past(reg_wdata[EBR_PP_MSB:EBR_SP0_LSB]))
        else $error("Routing field not taken on next cycle.");

    fields_hold_a: assert property (
        !(reg_wr && sel_hit) |=> $stable(fields_reg))
        else $error("Routing fields changed without a write.");

    reset_zero_a: assert property (
        @(posedge clk) disable iff (1'b0)
        sys_rst |=> fields_reg == '0 && pp_pin_oe == 21'h0)
        else $error("Routing not zero after reset.");

    mode1_map_a: assert property (
        fields_reg.pp == PP_SGUI |=> pp_pin_out[0] ==
            $past(periph_drv[FN_SPI].out[0]) && pp_pin_oe[20] ==
            $past(periph_drv[FN_I2S2].oe[3]))
        else $error("Mode 1 parallel map wrong.");

    mode2_gpio_a: assert property (
        fields_reg.pp == PP_GPIO |=> pp_pin_out[14] ==
            $past(periph_drv[FN_GPIO_PP].out[7]) && pp_pin_oe[0] == 1'b0)
        else $error("Mode 2 GPIO map wrong.");

    mode3_map_a: assert property (
        fields_reg.pp == PP_SPI_I2S3 |=> pp_pin_oe[4] == 1'b0 &&
            pp_pin_out[13] == $past(periph_drv[FN_I2S3].out[0]))
        else $error("Mode 3 parallel map wrong.");

    mode4_map_a: assert property (
        fields_reg.pp == PP_I2S2_UART |=> pp_pin_oe[3:0] == 4'h0 &&
            pp_pin_out[16] == $past(periph_drv[FN_UART].out[3]))
        else $error("Mode 4 parallel map wrong.");

    mode5_map_a: assert property (
        fields_reg.pp == PP_SPI_UART |=> pp_pin_oe[20:17] == 4'h0 &&
            pp_pin_out[3] == $past(periph_drv[FN_SPI].out[3]))
        else $error("Mode 5 parallel map wrong.");

    mode6_map_a: assert property (
        fields_reg.pp == PP_SPI_I2S_GPIO |=> pp_pin_out[13] ==
            $past(periph_drv[FN_I2S3].out[0]) && pp_pin_out[12] ==
            $past(periph_drv[FN_GPIO_PP].out[5]))
        else $error("Mode 6 parallel map wrong.");

    undef_idle_a: assert property (
        (fields_reg.pp == PP_UNDEF) [*2] |-> pp_pin_oe == 21'h0)
        else $error("Undefined parallel mode drives pins.");

    sp1_map_a: assert property (
        fields_reg.sp1 == SP_I2S_GPIO |=> sp1_pin_out[5] ==
            $past(periph_drv[FN_GPIO_SP1].out[5]) && sp1_pin_out[0] ==
            $past(periph_drv[FN_I2S1].out[0]))
        else $error("Serial port 1 mode 1 map wrong.");

    sp1_gpio_a: assert property (
        fields_reg.sp1 == SP_GPIO |=> sp1_pin_oe ==
            $past(periph_drv[FN_GPIO_SP1].oe[5:0]))
        else $error("Serial port 1 GPIO map wrong.");

    sp0_card_a: assert property (
        fields_reg.sp0 == SP_CARD |=> sp0_pin_out ==
            $past(periph_drv[FN_MMC0].out[5:0]))
        else $error("Serial port 0 card map wrong.");

    sp0_i2s_a: assert property (
        fields_reg.sp0 == SP_I2S_GPIO |=> sp0_pin_out[4] ==
            $past(periph_drv[FN_GPIO_SP0].out[4]) &&
            periph_in[FN_MMC0] == 8'h00)
        else $error("Serial port 0 mode 1 map wrong.");

    sp0_gpio_a: assert property (
        fields_reg.sp0 == SP_GPIO |=> periph_in[FN_GPIO_SP0][5:0] ==
            $past(sp0_pin_in) && periph_in[FN_I2S0] == 8'h00)
        else $error("Serial port 0 GPIO map wrong.");

endmodule : ebr_route_select
